// ==== verilog/asa_averager.v ====
// angle sample averager: paces 25 us samples, averages 2^sel, loads angle register
// assumes samples arrive synchronous to mclk_i as a one-cycle strobe
`include "asa_regs.vh"
`default_nettype none
module asa_averager #(
  parameter SAMPLE_CYCLES = `ASA_SAMPLE_CYCLES,
  parameter SELF_TEST_CYCLES = `ASA_SELF_TEST_CYCLES,
  parameter FIFO_DEPTH = `ASA_FIFO_DEPTH
) (
  // clock and reset
  input wire mclk_i,
  input wire reset_i,
  // nonvolatile configuration
  input wire [`ASA_SEL_W-1:0] nv_sample_count_select_i,
  input wire high_speed_mode_i,
  // front end samples
  input wire sample_valid_i,
  input wire [`ASA_ANGLE_W-1:0] sample_angle_i,
  input wire supply_low_i,
  // self-test request
  input wire logic_self_test_start_i,
  // angle output register and flags
  output reg [`ASA_ANGLE_W-1:0] angle_o,
  output reg angle_supply_low_o,
  output reg angle_update_o,
  output reg ready_o,
  output reg sample_strobe_o,
  output reg self_test_busy_o,
  output reg self_test_done_o,
  output reg sample_dropped_o
);
  localparam ST_CONFIG = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_TEST = 3'b100;
  localparam ACC_W = `ASA_ANGLE_W + 7;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`ASA_SEL_W-1:0] sel;
  reg [ACC_W-1:0] acc;
  reg [7:0] n_acc;
  reg low_acc;
  reg [15:0] tick_cnt;
  reg [31:0] test_cnt;
  wire fifo_in_ready;
  wire fifo_valid;
  wire [`ASA_ANGLE_W:0] fifo_data;
  wire [ACC_W-1:0] sum;
  wire [7:0] target;
  wire last;
  // window result helpers
  wire [ACC_W-1:0] mean;
  wire [`ASA_ANGLE_W-1:0] next_angle;
  wire next_low;
  // fifo drain handshake
  wire fifo_pop_ready;
  wire pop;

  // =====================================================
  // sample buffer
  asa_fifo #(
    .WIDTH(`ASA_ANGLE_W + 1),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i({supply_low_i, sample_angle_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop_ready),
    .out_data_o(fifo_data)
  );

  // =====================================================
  // control state
  always @* begin
    next_state = state;
    case (state)
      ST_CONFIG: next_state = ST_RUN;
      ST_RUN: if (logic_self_test_start_i) next_state = ST_TEST;
      ST_TEST: if (test_cnt == SELF_TEST_CYCLES - 1) next_state = ST_RUN;
      default: next_state = ST_CONFIG;
    endcase
  end

  // =====================================================
  // window arithmetic
  // count from selector
  assign target = 8'h01 << sel;
  assign sum = acc + {7'h00, fifo_data[`ASA_ANGLE_W-1:0]};
  assign last = (n_acc == target - 8'h01);
  assign mean = sum >> sel;
  assign next_angle = mean[`ASA_ANGLE_W-1:0];
  assign next_low = low_acc | fifo_data[`ASA_ANGLE_W];
  // samples drain only while running
  assign fifo_pop_ready = (state == ST_RUN);
  assign pop = fifo_pop_ready & fifo_valid;

  // =====================================================
  // configuration and averaging datapath
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_CONFIG;
      sel <= 3'h0;
      acc <= {ACC_W{1'b0}};
      n_acc <= 8'h00;
      low_acc <= 1'b0;
      angle_o <= 12'h000;
      angle_supply_low_o <= 1'b0;
      angle_update_o <= 1'b0;
      ready_o <= 1'b0;
      sample_dropped_o <= 1'b0;
    end else begin
      state <= next_state;
      angle_update_o <= 1'b0;
      // fifo refused a sample
      sample_dropped_o <= sample_valid_i & ~fifo_in_ready;
      if (state == ST_CONFIG) begin
        sel <= high_speed_mode_i ? `ASA_SEL_HIGH_SPEED : nv_sample_count_select_i;
        ready_o <= 1'b1;
      end
      if (pop) begin
        if (last) begin
          angle_o <= next_angle;
          angle_supply_low_o <= next_low;
          angle_update_o <= 1'b1;
          acc <= {ACC_W{1'b0}};
          n_acc <= 8'h00;
          low_acc <= 1'b0;
        end else begin
          acc <= sum;
          n_acc <= n_acc + 8'h01;
          low_acc <= next_low;
        end
      end
    end
  end

  // =====================================================
  // self-test timer
  // self-test run time
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      test_cnt <= 32'h0;
      self_test_busy_o <= 1'b0;
      self_test_done_o <= 1'b0;
    end else begin
      self_test_done_o <= 1'b0;
      if (state == ST_TEST) begin
        self_test_busy_o <= 1'b1;
        test_cnt <= test_cnt + 32'h1;
        // last timer cycle ends the test
        if (next_state == ST_RUN) begin
          self_test_busy_o <= 1'b0;
          self_test_done_o <= 1'b1;
          test_cnt <= 32'h0;
        end
      end
    end
  end

  // =====================================================
  // 25 us sampling pace for the front end
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt <= 16'h0000;
      sample_strobe_o <= 1'b0;
    end else begin
      sample_strobe_o <= 1'b0;
      if (tick_cnt == SAMPLE_CYCLES - 1) begin
        tick_cnt <= 16'h0000;
        sample_strobe_o <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== include/asa_regs.vh ====
// constants for the angle sample averager: widths, timing, self-test
// assumes a 200 MHz core clock
`ifndef ASA_REGS_VH
`define ASA_REGS_VH
`define ASA_CLK_MHZ 200
`define ASA_SAMPLE_PERIOD_NS 25000
`define ASA_SAMPLE_CYCLES (`ASA_SAMPLE_PERIOD_NS * `ASA_CLK_MHZ / 1000)
`define ASA_RESPONSE_NS 60000
`define ASA_RESPONSE_CYCLES (`ASA_RESPONSE_NS * `ASA_CLK_MHZ / 1000)
`define ASA_ANGLE_W 12
`define ASA_SEL_W 3
`define ASA_SEL_HIGH_SPEED 3'h0
`define ASA_SELF_TEST_MS 10
`define ASA_SELF_TEST_CYCLES (`ASA_SELF_TEST_MS * `ASA_CLK_MHZ * 1000)
`define ASA_FIFO_DEPTH 16
`endif

// ==== verilog/asa_fifo.v ====
// synchronous fifo of flip-flops with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`default_nettype none
module asa_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire reset_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  // honest full and empty from the fill count
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // pointers and count
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
  // storage, no reset needed
  always @(posedge mclk_i) begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end
endmodule
`default_nettype wire

// ==== verification/asa_props.sv ====
// checker for the averager: angle register, flags, pacing, self-test
// assumes bound to asa_averager on its single clock
`default_nettype none
module asa_props (
  input wire logic mclk_i, reset_i, sample_valid_i,
  input wire logic [11:0] angle_o,
  input wire logic angle_supply_low_o, angle_update_o, ready_o, sample_strobe_o,
  input wire logic self_test_busy_o, self_test_done_o, sample_dropped_o
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  hold_angle_a: assert property (!angle_update_o |-> $stable(angle_o))
    else $error("angle register moved without an update");
  hold_flag_a: assert property (!angle_update_o |-> $stable(angle_supply_low_o))
    else $error("supply flag moved without an update");
  ready_hold_a: assert property (ready_o |=> ready_o)
    else $error("ready dropped while running");
  no_early_a: assert property (!ready_o |-> !angle_update_o)
    else $error("update before configuration latched");
  ready_rise_a: assert property ($rose(ready_o) |-> !$past(reset_i))
    else $error("ready rose too early");
  strobe_gap_a: assert property (sample_strobe_o |=> !sample_strobe_o [*8])
    else $error("sample pace strobes too close");
  drop_cause_a: assert property (sample_dropped_o |-> $past(sample_valid_i))
    else $error("drop flagged without a sample");
  test_quiet_a: assert property (self_test_busy_o && $past(self_test_busy_o, 2)
    |-> !angle_update_o)
    else $error("update during self-test");
  done_after_a: assert property (self_test_done_o |-> $past(self_test_busy_o))
    else $error("self-test done without busy");
  cover property (angle_update_o);
  cover property (sample_dropped_o);
  cover property (self_test_done_o);
endmodule
bind asa_averager asa_props u_props (.mclk_i, .reset_i, .sample_valid_i, .angle_o,
  .angle_supply_low_o, .angle_update_o, .ready_o, .sample_strobe_o, .self_test_busy_o,
  .self_test_done_o, .sample_dropped_o);
`default_nettype wire

// ==== verification/asa_port_reader.sv ====
// output-port side model: reads the angle register at each update
// assumes the same clock as the averager
`default_nettype none
module asa_port_reader (
  input wire logic mclk_i,
  input wire logic [11:0] angle_i,
  input wire logic supply_low_i,
  input wire logic update_i
);
  timeunit 1ns; timeprecision 1ps;
  logic [12:0] got[$];
  always @(posedge mclk_i) if (update_i === 1'b1) got.push_back({supply_low_i, angle_i});
endmodule
`default_nettype wire

// ==== verification/asa_averager_test.sv ====
// testbench: every code, high-speed forwarding, fifo overflow in self-test
// assumes the port reader model and the bound checker
`default_nettype none
module asa_averager_test;
  timeunit 1ns; timeprecision 1ps;
  logic mclk_i = 0, reset_i = 1, high_speed_mode_i = 0, sample_valid_i = 0;
  logic supply_low_i = 0, logic_self_test_start_i = 0;
  logic [2:0] nv_sample_count_select_i = 0;
  logic [11:0] sample_angle_i = 0, angle_o;
  logic angle_supply_low_o, angle_update_o, ready_o, sample_strobe_o;
  logic self_test_busy_o, self_test_done_o, sample_dropped_o;
  int n_fail = 0, num_checks = 0, cyc = 0, drops = 0, seed = 32'hd865, gap = -1;
  localparam int SC = 50;
  logic [12:0] exp_q[$];
  always #2.5 mclk_i = ~mclk_i;
  asa_averager #(.SAMPLE_CYCLES(SC), .SELF_TEST_CYCLES(40)) DUT (.*);
  asa_port_reader rd (.mclk_i, .angle_i(angle_o), .supply_low_i(angle_supply_low_o),
    .update_i(angle_update_o));
  // cycle count, drop count and hang cut-off
  always @(posedge mclk_i) begin
    cyc++;
    drops += (sample_dropped_o === 1'b1);
    // pace strobe spacing, restarted by every reset
    if (reset_i) gap = -1;
    else if (sample_strobe_o === 1'b1) begin
      if (gap >= 0) chk("strobe gap", 13'(SC - 1), 13'(gap));
      gap = 0;
    end else if (gap >= 0) gap++;
    if (cyc == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(string what, logic [12:0] e, logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic compare(int n);
    chk("updates", 13'(n), 13'(rd.got.size()));
    for (int i = 0; i < n && i < rd.got.size(); i++) chk("angle", exp_q[i], rd.got[i]);
    exp_q.delete();
  endtask
  // reset with a setting, send two windows, compare means
  task automatic run(logic h, logic [2:0] s);
    int m, sum;
    logic low;
    logic [31:0] v;
    m = h ? 0 : s;
    reset_i <= 1;
    high_speed_mode_i <= h;
    nv_sample_count_select_i <= s;
    repeat (10) @(posedge mclk_i);
    reset_i <= 0;
    repeat (3) @(posedge mclk_i);
    // no programming pulses: the setting arrives as a level
    chk("ready", 1, ready_o);
    rd.got.delete();
    for (int w = 0; w < 2; w++) begin
      sum = 0;
      low = 0;
      for (int i = 0; i < (1 << m); i++) begin
        v = $random(seed);
        sample_valid_i <= 1;
        sample_angle_i <= v[11:0];
        supply_low_i <= (v[15:13] == 0);
        sum += v[11:0];
        low |= (v[15:13] == 0);
        @(posedge mclk_i);
        sample_valid_i <= 0;
        @(posedge mclk_i);
      end
      exp_q.push_back({low, 12'(sum >> m)});
    end
    repeat (4) @(posedge mclk_i);
    compare(2);
  endtask
  // samples pile up during self-test until the fifo refuses
  task automatic overflow();
    logic [31:0] v;
    rd.got.delete();
    drops = 0;
    supply_low_i <= 0;
    logic_self_test_start_i <= 1;
    @(posedge mclk_i);
    logic_self_test_start_i <= 0;
    for (int i = 0; i < 20; i++) begin
      v = $random(seed);
      sample_valid_i <= 1;
      sample_angle_i <= v[11:0];
      exp_q.push_back({1'b0, v[11:0]});
      @(posedge mclk_i);
    end
    sample_valid_i <= 0;
    chk("busy", 1, self_test_busy_o);
    for (int i = 0; i < 200 && self_test_done_o !== 1'b1; i++) @(posedge mclk_i);
    chk("done", 1, self_test_done_o);
    repeat (40) @(posedge mclk_i);
    chk("dropped", 1, 13'(drops > 0));
    compare(20 - drops);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 8; s++) run(0, 3'(s));
    run(1, 3'h5);
    overflow();
    report_and_stop();
  end
endmodule
`default_nettype wire
